// ### ieh_top.sv
// Interrupt enable hierarchy: local, module and global gating, group id.
// Assumes source flags are kept by peripherals and cleared by software.
`timescale 1ns/1ps
`default_nettype none
module ieh_top
  import ieh_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ieh_grp0_t grp0_i,
  input wire ieh_grp1_t grp1_i,
  input wire ieh_grp2_t grp2_i,
  input wire logic global_irq_on_wr_i,
  input wire logic global_irq_on_i,
  input wire logic module_mask_wr_i,
  input wire logic [GRP_N-1:0] module_mask_i,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  output logic irq_req_o,
  output logic irq_take_o,
  output logic global_irq_on_o,
  output logic [GRP_N-1:0] module_mask_reg_o,
  output logic [GRP_N-1:0] pending_group_reg_o,
  output logic [ID1_W-1:0] group1_source_id_o,
  output logic [ID2_W-1:0] group2_source_id_o,
  output logic in_service_o
);

  typedef struct packed {
    logic global_irq_on;
    logic [GRP_N-1:0] mask;
    logic [GRP_N-1:0] pending;
    logic [ID1_W-1:0] id1;
    logic [ID2_W-1:0] id2;
    ieh_state_t state;
  } ieh_regs_t;

  ieh_regs_t r_ff;
  ieh_regs_t nxt_r;

  // Per-source gating results
  logic [G1_P6_W-1:0] p6_pend;
  logic supply_pend;
  logic i2ch_pend;
  logic [SPIT_W-1:0] spit_en;
  logic spit_pend;
  logic i2ct_pend;
  logic g0_port_pend;
  logic g0_timer_pend;

  // Per-group results
  logic g0_pend;
  logic g1_pend;
  logic g2_pend;
  logic [GRP_N-1:0] grp_pend;
  logic [ID1_W-1:0] id1_next;
  logic [ID2_W-1:0] id2_next;

  // Register-side and core-side control
  logic nxt_global;
  logic [GRP_N-1:0] nxt_mask;
  ieh_state_t nxt_state;
  logic [GRP_N-1:0] open_grp;
  logic req;
  logic ack_ok;
  logic ret_ok;

  // Flags arrive raw from peripherals: they set regardless of enables
  ieh_src_gate #(.W(G0_PORT_W)) u_g0 (
    .flag_i(grp0_i.port_flag),
    .en_i(grp0_i.port_en),
    .pending_o(g0_port_pend)
  );
  ieh_src_gate #(.W(I2CH_W)) u_i2ch (
    .flag_i(grp1_i.i2ch_flag),
    .en_i(grp1_i.i2ch_en),
    .pending_o(i2ch_pend)
  );
  ieh_src_gate #(.W(SPIT_W)) u_spit (
    .flag_i(grp1_i.spit_flag),
    .en_i(spit_en),
    .pending_o(spit_pend)
  );
  ieh_src_gate #(.W(I2CT_W)) u_i2ct (
    .flag_i(grp2_i.i2ct_flag),
    .en_i(grp2_i.i2ct_en),
    .pending_o(i2ct_pend)
  );

  // One SPI target enable gates all three of its flags
  assign spit_en = {SPIT_W{grp1_i.spi_target_irq_on}};

  // Group 0: ports 0-2 and timer 1, no source id register
  always_comb begin
    // Timer wrap has its own local enable
    g0_timer_pend = grp0_i.timer_wrap_flag & grp0_i.timer_wrap_irq_on;
    g0_pend = g0_port_pend | g0_timer_pend;
  end

  // Group 1: port 6, supply monitor, I2C host, SPI target
  always_comb begin
    p6_pend = grp1_i.p6_flag & grp1_i.p6_en;
    supply_pend = grp1_i.supply_flag & grp1_i.supply_en;
    g1_pend = (|p6_pend) | supply_pend | i2ch_pend | spit_pend;
  end

  // Group 2: I2C target sources only
  always_comb begin
    g2_pend = i2ct_pend;
  end

  // Pending bits use local enables only; masks apply to the request
  always_comb begin
    grp_pend = '0;
    grp_pend[GRP0] = g0_pend;
    grp_pend[GRP1] = g1_pend;
    grp_pend[GRP2] = g2_pend;
  end

  // Source ids tell the handler which member of a group asked
  always_comb begin
    id1_next = '0;
    id1_next[G1_P6_W-1:0] = p6_pend;
    id1_next[ID1_SUPPLY] = supply_pend;
    id1_next[ID1_I2C_HOST] = i2ch_pend;
    id1_next[ID1_SPI_TGT] = spit_pend;
    id2_next = ID2_W'(g2_pend);
  end

  // Local enables stay with peripherals; only masks and global are here
  always_comb begin
    nxt_global = r_ff.global_irq_on;
    nxt_mask = r_ff.mask;
    if (global_irq_on_wr_i) begin
      nxt_global = global_irq_on_i;
    end
    if (module_mask_wr_i) begin
      // One write opens or closes several groups at once
      nxt_mask = module_mask_i;
    end
  end

  // Global and module levels stacked over the local ones
  always_comb begin
    open_grp = r_ff.mask & {GRP_N{r_ff.global_irq_on}};
    // A flag left set keeps this high after return, so it repeats
    req = |(r_ff.pending & open_grp);
    // An ack without a request is ignored
    ack_ok = req && irq_ack_i;
    // Return only matters while busy
    ret_ok = irq_return_i;
  end

  // Only one interrupt in service; requests wait for return
  always_comb begin
    nxt_state = r_ff.state;
    case (r_ff.state)
      IEH_IDLE: begin
        if (ack_ok) begin
          nxt_state = IEH_BUSY;
        end
      end
      IEH_BUSY: begin
        if (ret_ok) begin
          nxt_state = IEH_IDLE;
        end
      end
      default: begin
        nxt_state = IEH_IDLE;
      end
    endcase
  end

  // Register update; reset wins over any write in the same cycle
  always_comb begin
    nxt_r = r_ff;
    nxt_r.global_irq_on = nxt_global;
    nxt_r.mask = nxt_mask;
    nxt_r.pending = grp_pend;
    nxt_r.id1 = id1_next;
    nxt_r.id2 = id2_next;
    nxt_r.state = nxt_state;
    if (!rst_n_i) begin
      // Ids and pending restart empty; flags are held outside
      nxt_r = '0;
      nxt_r.global_irq_on = GLOBAL_RST;
      nxt_r.mask = MASK_RST;
      nxt_r.state = IEH_IDLE;
    end
  end

  // Single register stage for the whole block state
  always_ff @(posedge clk_i) begin
    r_ff <= nxt_r;
  end

  // Combinational on purpose: handshake toward the core
  assign irq_req_o = req && (r_ff.state == IEH_IDLE);
  assign irq_take_o = irq_req_o && irq_ack_i;

  // Register views for software
  assign global_irq_on_o = r_ff.global_irq_on;
  assign module_mask_reg_o = r_ff.mask;
  assign pending_group_reg_o = r_ff.pending;
  assign group1_source_id_o = r_ff.id1;
  assign group2_source_id_o = r_ff.id2;
  assign in_service_o = (r_ff.state == IEH_BUSY);

endmodule
`default_nettype wire

// ### ieh_pkg.sv
// Package for the interrupt enable hierarchy: group indices, widths, types.
// Assumes a single core clock and a synchronous active-low reset.
package ieh_pkg;

  localparam int GRP_N = 3;
  localparam int GRP0 = 0;
  localparam int GRP1 = 1;
  localparam int GRP2 = 2;

  // Group 1 source id bit positions
  localparam int G1_P6_W = 7;
  localparam int ID1_SUPPLY = 7;
  localparam int ID1_I2C_HOST = 8;
  localparam int ID1_SPI_TGT = 9;
  localparam int ID1_W = 10;
  localparam int ID2_W = 1;

  // Source counts for all three groups
  localparam int G0_PORT_W = 24;
  localparam int I2CH_W = 8;
  localparam int SPIT_W = 3;
  localparam int SPIT_DONE = 0;
  localparam int SPIT_WCOL = 1;
  localparam int SPIT_OVR = 2;
  localparam int I2CT_W = 10;

  localparam logic GLOBAL_RST = 1'h0;
  localparam logic [GRP_N-1:0] MASK_RST = 3'h0;

  typedef enum logic {IEH_IDLE, IEH_BUSY} ieh_state_t;

  // Pending/enable pair per group
  typedef struct packed {
    logic [G0_PORT_W-1:0] port_flag;
    logic [G0_PORT_W-1:0] port_en;
    logic timer_wrap_flag;
    logic timer_wrap_irq_on;
  } ieh_grp0_t;

  typedef struct packed {
    logic [G1_P6_W-1:0] p6_flag;
    logic [G1_P6_W-1:0] p6_en;
    logic supply_flag;
    logic supply_en;
    logic [I2CH_W-1:0] i2ch_flag;
    logic [I2CH_W-1:0] i2ch_en;
    logic [SPIT_W-1:0] spit_flag;
    logic spi_target_irq_on;
  } ieh_grp1_t;

  typedef struct packed {
    logic [I2CT_W-1:0] i2ct_flag;
    logic [I2CT_W-1:0] i2ct_en;
  } ieh_grp2_t;

endpackage

// ### ieh_src_gate.sv
// Local gating of one group of flag/enable pairs into one pending bit.
// Assumes flags and enables come from logic on the core clock.
`timescale 1ns/1ps
`default_nettype none
module ieh_src_gate #(
  parameter int W = 8
) (
  input wire logic [W-1:0] flag_i,
  input wire logic [W-1:0] en_i,
  output logic pending_o
);
  // Flag counts only with its own local enable
  assign pending_o = |(flag_i & en_i);
endmodule
`default_nettype wire

// ### ieh_core_model.sv
// Core model: takes requests and ends each handler a few cycles later.
// Assumes the clock and synchronous reset of ieh_top.
`timescale 1ns/1ps
`default_nettype none
module ieh_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic irq_req_i,
  input wire logic hold_i,
  output logic irq_ack_o,
  output logic irq_return_o
);
  logic [2:0] cnt_ff;
  always_ff @(posedge clk_i) begin
    // Hold models a core busy elsewhere; one ack pulse per request
    irq_ack_o <= rst_n_i && irq_req_i && !hold_i && !irq_ack_o;
    irq_return_o <= rst_n_i && cnt_ff == 3'h1;
    cnt_ff <= !rst_n_i ? 3'h0 : irq_ack_o ? 3'h4 :
      cnt_ff - {2'h0, cnt_ff != 3'h0};
  end
endmodule
`default_nettype wire

// ### ieh_top_assertions.sv
// Checker on the ports of ieh_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ieh_top_assertions import ieh_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire ieh_grp1_t grp1_i,
  input wire ieh_grp2_t grp2_i,
  input wire logic global_irq_on_wr_i,
  input wire logic global_irq_on_i,
  input wire logic module_mask_wr_i,
  input wire logic [GRP_N-1:0] module_mask_i,
  input wire logic irq_req_o,
  input wire logic irq_take_o,
  input wire logic global_irq_on_o,
  input wire logic [GRP_N-1:0] module_mask_reg_o,
  input wire logic [GRP_N-1:0] pending_group_reg_o,
  input wire logic [ID1_W-1:0] group1_source_id_o,
  input wire logic in_service_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic hit = |(pending_group_reg_o & module_mask_reg_o);
  req_gate_a: assert property (irq_req_o |-> global_irq_on_o && hit)
    else $error("request through closed gate");
  req_on_a: assert property (global_irq_on_o && hit && !in_service_o
    |-> irq_req_o) else $error("open request missing");
  glob_wr_a: assert property (global_irq_on_wr_i
    |=> global_irq_on_o == $past(global_irq_on_i)) else $error("global");
  mask_wr_a: assert property (module_mask_wr_i
    |=> module_mask_reg_o == $past(module_mask_i)) else $error("mask");
  svc_block_a: assert property (in_service_o |-> !irq_req_o)
    else $error("request in service");
  take_svc_a: assert property (irq_take_o |=> in_service_o)
    else $error("take without service");
  grp2_pend_a: assert property ($past(rst_n_i) |->
    pending_group_reg_o[GRP2] == $past(|(grp2_i.i2ct_flag & grp2_i.i2ct_en)))
    else $error("group 2 pending");
  spi_id_a: assert property ($past(rst_n_i) |->
    group1_source_id_o[ID1_SPI_TGT] ==
    $past(|grp1_i.spit_flag & grp1_i.spi_target_irq_on)) else $error("spi");
  cover property (irq_take_o);
  cover property (in_service_o ##1 !in_service_o);
  cover property (global_irq_on_wr_i && !global_irq_on_i);
endmodule
bind ieh_top ieh_top_assertions u_chk (.*);
`default_nettype wire

// ### ieh_top_bench.sv
// Bench for ieh_top: reset, random gating and one service round.
// Assumes ieh_pkg, ieh_top and ieh_core_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module ieh_top_bench import ieh_pkg::*;;
  logic clk_i = '0, rst_n_i = '0, global_irq_on_wr_i = '0, global_irq_on_i = '0;
  logic module_mask_wr_i = '0, hold = '1, irq_ack_i, irq_return_i, irq_req_o;
  logic irq_take_o, global_irq_on_o, group2_source_id_o, in_service_o;
  logic [GRP_N-1:0] module_mask_i = '0, module_mask_reg_o, pending_group_reg_o;
  logic [ID1_W-1:0] group1_source_id_o;
  ieh_grp0_t grp0_i = '0;
  ieh_grp1_t grp1_i = '0;
  ieh_grp2_t grp2_i = '0;
  logic [20:0] q[$], last, e;
  int errors = 0, checks_done = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  ieh_top u_dut (.*);
  ieh_core_model u_core (.clk_i, .rst_n_i, .irq_req_i(irq_req_o), .hold_i(hold),
    .irq_ack_o(irq_ack_i), .irq_return_o(irq_return_i));
  always @(negedge clk_i) if (q.size() > 0) begin
    e = q.pop_front();
    `CHK("outputs", e, {irq_req_o, in_service_o, global_irq_on_o,
      module_mask_reg_o, pending_group_reg_o, group1_source_id_o,
      group2_source_id_o, irq_take_o})
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      tally_and_finish();
    end
  end
  // Sparse bits so that groups are often idle
  function automatic logic [63:0] sp();
    return {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
  endfunction
  task automatic step(input logic [127:0] v, input logic [31:0] x);
    ieh_grp0_t a0;
    ieh_grp1_t a1;
    ieh_grp2_t a2;
    logic [2:0] p;
    logic [ID1_W-1:0] i1;
    {a0, a1, a2} = v[105:0];
    i1 = {|a1.spit_flag & a1.spi_target_irq_on, |(a1.i2ch_flag & a1.i2ch_en),
      a1.supply_flag & a1.supply_en, a1.p6_flag & a1.p6_en};
    p = {|(a2.i2ct_flag & a2.i2ct_en), |i1, |(a0.port_flag & a0.port_en) |
      (a0.timer_wrap_flag & a0.timer_wrap_irq_on)};
    @(posedge clk_i);
    {grp0_i, grp1_i, grp2_i, global_irq_on_i, module_mask_i,
      global_irq_on_wr_i, module_mask_wr_i} <= {v[105:0], x[3:0], 2'h3};
    @(posedge clk_i);
    {global_irq_on_wr_i, module_mask_wr_i} <= 2'h0;
    last = {x[3] & |(p & x[2:0]), 1'h0, x[3:0], p, i1, p[2], 1'h0};
    q.push_back(last);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(33));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    q.push_back('0);
    $display("reset test done");
    repeat (60) step({sp(), sp()}, $urandom);
    $display("gating test done");
    step(128'h0401, 32'h000f);
    hold <= 1'h0;
    repeat (20) if (!in_service_o) @(negedge clk_i);
    @(posedge clk_i);
    q.push_back({2'h1, last[18:0]});
    repeat (20) if (in_service_o) @(negedge clk_i);
    @(posedge clk_i);
    q.push_back({last[20:1], 1'h1});
    repeat (2) @(negedge clk_i);
    $display("service test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
